// ---- ucir_defines.vh ----
// Register offsets, field positions, reset values and timing for the USB config/irq block
`ifndef UCIR_DEFINES_VH
`define UCIR_DEFINES_VH
`define UCIR_AW 16
`define UCIR_OFS_EXT_INDEX 16'h4038
`define UCIR_OFS_EXT_DATA 16'h403a
`define UCIR_OFS_INPUT_CTRL 16'h4040
`define UCIR_OFS_RSVD_WORD 16'h4042
`define UCIR_OFS_PIN_STATUS 16'h4044
`define UCIR_OFS_IRQ_EN0 16'h4046
`define UCIR_OFS_IRQ_EN1 16'h4048
`define UCIR_OFS_IRQ_ST0 16'h404a
`define UCIR_OFS_IRQ_ST1 16'h404c
`define UCIR_OFS_IRQ_MSK0 16'h404e
`define UCIR_OFS_IRQ_MSK1 16'h4050
`define UCIR_OFS_SOFT_RESET 16'h4052
`define UCIR_OFS_WAIT_STATES 16'h4054
`define UCIR_IDX_STRING_CTRL 8'h08
`define UCIR_IDX_MAX_POWER 8'h09
`define UCIR_IDX_TOGGLES 8'h0a
`define UCIR_IDX_RSVD_B 8'h0b
`define UCIR_IDX_TX_FIFO_MODE 8'h0c
`define UCIR_RST_INPUT_CTRL 8'h0d
`define UCIR_RST_STRING_CTRL 1'h1
`define UCIR_RST_MAX_POWER 8'hfa
`define UCIR_RST_ST0 8'h02
`define UCIR_MAX_POWER_LIMIT 8'hfa
`define UCIR_SOFT_RESET_KEY 8'ha4
`define UCIR_INPUT_CTRL_MASK 8'h4c
`define UCIR_BIT_RX_ENABLE 6
`define UCIR_BIT_XFER_BULK 3
`define UCIR_BIT_WAKE_N 2
`define UCIR_BIT_DETECT 1
`define UCIR_BIT_PULLUP 0
`define UCIR_BIT_TOG_TX 7
`define UCIR_BIT_TOG_RX 6
`define UCIR_BIT_TOG_MBIN 5
`define UCIR_BIT_TOG_MBOUT 4
`define UCIR_ST0_MASK 8'h42
`define UCIR_ST1_MASK 8'h51
`define UCIR_BIT_ST0_RESET 1
`define UCIR_BIT_ST0_CONNECT 6
`define UCIR_BIT_ST1_DISCONN 6
`define UCIR_BIT_ST1_CONFIG 4
`define UCIR_BIT_ST1_EPREQ 0
`define UCIR_TOGGLE_DELAY 12
`define UCIR_DEBOUNCE_MS 500
`define UCIR_CLK_KHZ 250000
`endif

// ---- ucir_host_model.sv ----
// Behavioural host-side partner: bus line levels, port reset and transfer completions
`timescale 1ns/10ps
module ucir_host_model (
  input wire clk_i,
  output logic [3:0] lines_o,
  output logic [4:0] pulse_o,
  output logic cable_o
);
  // Cable starts plugged so the detect filter sees a steady level until the plug task changes it
  initial begin
    lines_o = 4'h0;
    pulse_o = 5'h0;
    cable_o = 1'b1;
  end
  // Order: connect, disconnect, configured, endpoint request
  task automatic lines(input logic [3:0] v);
    @(posedge clk_i);
    lines_o <= v;
  endtask
  // Plug or unplug the cable at a clock edge
  task automatic plug(input logic v);
    @(posedge clk_i);
    cable_o <= v;
  endtask
  // Order: port reset, then done for endpoints 4, 3, 2, 1
  task automatic pulse(input logic [4:0] v);
    @(posedge clk_i);
    pulse_o <= v;
    @(posedge clk_i);
    pulse_o <= 5'h0;
  endtask
endmodule // ucir_host_model

// ---- ucir_regs.v ----
// USB client configuration, control and interrupt register bank
`timescale 1ns/10ps
`include "ucir_defines.vh"

module ucir_regs #(
  parameter DEBOUNCE_CYCLES = (`UCIR_CLK_KHZ * `UCIR_DEBOUNCE_MS)
) (
  input wire clk_i,
  input wire nrst_i,
  input wire [15:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [15:0] rdata_o,
  input wire cable_detect_input_i,
  input wire host_connect_i,
  input wire host_disconnect_i,
  input wire dev_configured_i,
  input wire ep_request_i,
  input wire function_reset_event_i,
  input wire tx_endpoint_valid_i,
  input wire tx_fifo_has_data_i,
  input wire tx_in_done_i,
  input wire rx_out_done_i,
  input wire mbox_in_done_i,
  input wire mbox_out_done_i,
  output reg diff_receiver_enable_o,
  output reg xfer_bulk_o,
  output reg remote_wake_start_o,
  output reg line_pullup_output_o,
  output reg string_enable_o,
  output reg [7:0] max_power_o,
  output reg tx_endpoint_toggle_o,
  output reg rx_endpoint_toggle_o,
  output reg mailbox_in_toggle_o,
  output reg mailbox_out_toggle_o,
  output reg tx_send_allowed_o,
  output reg [1:0] wait_states_o,
  output reg usb_module_reset_o,
  output reg irq_o
);
  // Width of the toggle read-back delay counter
  localparam TW = 4;

  reg [7:0] ext_index_q;
  reg [7:0] input_ctrl_q;
  reg string_en_q;
  reg [7:0] max_power_q;
  reg [3:0] tog_q;
  reg [3:0] tog_rd_q;
  reg [3:0] tog_pend_q;
  reg [TW-1:0] tog_cnt_q;
  reg tx_mode_q;
  reg pullup_q;
  reg [7:0] en0_q;
  reg [7:0] en1_q;
  reg [7:0] st0_q;
  reg [7:0] st1_q;
  reg [1:0] wait_q;
  reg [2:0] ev_prev_q;
  reg ev_init_q;
  reg det_s1_q;
  reg det_s2_q;
  reg det_raw_q;
  reg det_stable_q;
  reg [31:0] deb_cnt_q;
  reg [2:0] ev_s1_q;
  reg [2:0] ev_s2_q;
  reg fre_s1_q;
  reg fre_s2_q;
  reg fre_prev_q;
  reg [7:0] ext_rd;
  reg [15:0] rd_d;
  reg [3:0] tog_evt;
  reg [7:0] st0_d;
  reg [7:0] st1_d;
  reg cnt_s1_q;
  reg cnt_s2_q;

  wire wr_ext = wr_i && (addr_i == `UCIR_OFS_EXT_DATA);
  wire wr_tog = wr_ext && (ext_index_q == `UCIR_IDX_TOGGLES);
  wire [7:0] msk0 = st0_q & en0_q;
  wire [7:0] msk1 = st1_q & en1_q;
  wire [2:0] ev_fall = ev_prev_q & ~ev_s2_q;
  wire fre_rise = fre_s2_q & ~fre_prev_q;
  wire host_connect_s = cnt_s2_q;
  wire [7:0] set0 = {1'b0, host_connect_s, 4'h0, fre_rise, 1'b0};
  wire [7:0] set1 = {1'b0, ev_fall[2], 1'b0, ev_fall[1], 3'h0, ev_fall[0]} & {8{ev_init_q}};
  // Only the low byte is implemented; upper write data is ignored
  wire [7:0] wlo = wdata_i[7:0];
  wire wr_ic = wr_i && (addr_i == `UCIR_OFS_INPUT_CTRL);
  wire wr_st0 = wr_i && (addr_i == `UCIR_OFS_IRQ_ST0);
  wire wr_st1 = wr_i && (addr_i == `UCIR_OFS_IRQ_ST1);
  wire wr_key = wr_i && (addr_i == `UCIR_OFS_SOFT_RESET) && (wlo == `UCIR_SOFT_RESET_KEY);
  wire [7:0] clr0 = wr_st0 ? wlo : 8'h00;
  wire [7:0] clr1 = wr_st1 ? wlo : 8'h00;
  wire [3:0] tog_d;
  wire deb_done = (deb_cnt_q >= DEBOUNCE_CYCLES - 1);

  // Extended index and simple registers
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_index_q <= 8'h00;
      input_ctrl_q <= `UCIR_RST_INPUT_CTRL;
      string_en_q <= `UCIR_RST_STRING_CTRL;
      max_power_q <= `UCIR_RST_MAX_POWER;
      tx_mode_q <= 1'b0;
      pullup_q <= 1'b0;
      en0_q <= 8'h00;
      en1_q <= 8'h00;
      wait_q <= 2'h0;
    end else if (wr_i) begin
      case (addr_i)
        `UCIR_OFS_EXT_INDEX: ext_index_q <= wlo;
        // Reserved input-control bits are dropped so they read back as zero after a write; reset loads reserved bit 0 as 1
        `UCIR_OFS_INPUT_CTRL: input_ctrl_q <= wlo & `UCIR_INPUT_CTRL_MASK;
        `UCIR_OFS_PIN_STATUS: pullup_q <= wlo[`UCIR_BIT_PULLUP];
        `UCIR_OFS_IRQ_EN0: en0_q <= wlo & `UCIR_ST0_MASK;
        `UCIR_OFS_IRQ_EN1: en1_q <= wlo & `UCIR_ST1_MASK;
        `UCIR_OFS_WAIT_STATES: wait_q <= wlo[1:0];
        `UCIR_OFS_EXT_DATA: begin
          case (ext_index_q)
            `UCIR_IDX_STRING_CTRL: string_en_q <= wlo[0];
            `UCIR_IDX_MAX_POWER: begin
              // Clamp keeps the descriptor within the bus power limit
              if (wlo > `UCIR_MAX_POWER_LIMIT) begin
                max_power_q <= `UCIR_MAX_POWER_LIMIT;
              end else begin
                max_power_q <= wlo;
              end
            end
            `UCIR_IDX_TX_FIFO_MODE: tx_mode_q <= wlo[0];
            default: ;
          endcase
        end
        default: ;
      endcase
    end
  end

  // Data toggles: the endpoint engine flips each after a successful transfer
  always @* begin
    tog_evt = {tx_in_done_i, rx_out_done_i, mbox_in_done_i, mbox_out_done_i};
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_tog
      // A CPU write overrides a completion that lands in the same cycle
      assign tog_d[g] = wr_tog ? wlo[`UCIR_BIT_TOG_MBOUT + g] : (tog_q[g] ^ tog_evt[g]);
    end
  endgenerate

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tog_q <= 4'h0;
      tog_rd_q <= 4'h0;
      tog_pend_q <= 4'h0;
      tog_cnt_q <= 4'h0;
    end else begin
      tog_q <= tog_d;
      if (wr_tog) begin
        tog_pend_q <= 4'hf;
        tog_cnt_q <= 4'h0;
      end else begin
        if (tog_pend_q != 4'h0) begin
          // Read-back lags a write by the documented settle time
          if (tog_cnt_q == (`UCIR_TOGGLE_DELAY - 1)) begin
            tog_pend_q <= 4'h0;
          end else begin
            tog_cnt_q <= tog_cnt_q + 4'h1;
          end
        end
      end
      if (tog_pend_q == 4'h0 && !wr_tog) begin
        tog_rd_q <= tog_q;
      end
    end
  end

  // Input synchronisers for pins and internal events from other logic
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      det_s1_q <= 1'b0;
      det_s2_q <= 1'b0;
      ev_s1_q <= 3'h0;
      ev_s2_q <= 3'h0;
      fre_s1_q <= 1'b0;
      fre_s2_q <= 1'b0;
      cnt_s1_q <= 1'b0;
      cnt_s2_q <= 1'b0;
    end else begin
      det_s1_q <= cable_detect_input_i;
      det_s2_q <= det_s1_q;
      ev_s1_q <= {host_disconnect_i, dev_configured_i, ep_request_i};
      ev_s2_q <= ev_s1_q;
      fre_s1_q <= function_reset_event_i;
      fre_s2_q <= fre_s1_q;
      cnt_s1_q <= host_connect_i;
      cnt_s2_q <= cnt_s1_q;
    end
  end

  // Debounce: status follows the pin only after it has held steady
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      det_raw_q <= 1'b0;
      det_stable_q <= 1'b0;
      deb_cnt_q <= 32'h0;
    end else begin
      det_raw_q <= det_s2_q;
      // Counter restarts on every change, so bounces never reach the status
      if (det_s2_q != det_raw_q) begin
        deb_cnt_q <= 32'h0;
      end else if (deb_done) begin
        det_stable_q <= det_raw_q;
      end else begin
        deb_cnt_q <= deb_cnt_q + 32'h1;
      end
    end
  end

  // Next status: a set beats a clear in the same cycle so no event is lost
  always @* begin
    st0_d = ((st0_q & ~clr0) | set0) & `UCIR_ST0_MASK;
    st1_d = ((st1_q & ~clr1) | set1) & `UCIR_ST1_MASK;
  end

  // Sticky status registers
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st0_q <= `UCIR_RST_ST0;
      st1_q <= 8'h00;
      ev_prev_q <= 3'h0;
      ev_init_q <= 1'b0;
      fre_prev_q <= 1'b0;
    end else begin
      ev_prev_q <= ev_s2_q;
      ev_init_q <= 1'b1;
      fre_prev_q <= fre_s2_q;
      st0_q <= st0_d;
      st1_q <= st1_d;
    end
  end

  // Extended read mux
  // Toggles read back through the delayed copy, never the live bits
  always @* begin
    case (ext_index_q)
      `UCIR_IDX_STRING_CTRL: ext_rd = {7'h0, string_en_q};
      `UCIR_IDX_MAX_POWER: ext_rd = max_power_q;
      `UCIR_IDX_TOGGLES: ext_rd = {tog_rd_q, 4'h0};
      `UCIR_IDX_TX_FIFO_MODE: ext_rd = {7'h0, tx_mode_q};
      default: ext_rd = 8'h00;
    endcase
  end

  // Unmapped, reserved and write-only offsets read back as zero
  always @* begin
    case (addr_i)
      `UCIR_OFS_EXT_INDEX: rd_d = {8'h00, ext_index_q};
      `UCIR_OFS_EXT_DATA: rd_d = {8'h00, ext_rd};
      `UCIR_OFS_INPUT_CTRL: rd_d = {8'h00, input_ctrl_q};
      `UCIR_OFS_PIN_STATUS: rd_d = {14'h0, det_stable_q, pullup_q};
      `UCIR_OFS_IRQ_EN0: rd_d = {8'h00, en0_q};
      `UCIR_OFS_IRQ_EN1: rd_d = {8'h00, en1_q};
      `UCIR_OFS_IRQ_ST0: rd_d = {8'h00, st0_q};
      `UCIR_OFS_IRQ_ST1: rd_d = {8'h00, st1_q};
      `UCIR_OFS_IRQ_MSK0: rd_d = {8'h00, msk0};
      `UCIR_OFS_IRQ_MSK1: rd_d = {8'h00, msk1};
      `UCIR_OFS_WAIT_STATES: rd_d = {14'h0, wait_q};
      default: rd_d = 16'h0000;
    endcase
  end

  // Registered outputs
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 16'h0000;
      diff_receiver_enable_o <= 1'b0;
      xfer_bulk_o <= 1'b0;
      remote_wake_start_o <= 1'b0;
      line_pullup_output_o <= 1'b0;
      string_enable_o <= 1'b0;
      max_power_o <= 8'h00;
      tx_endpoint_toggle_o <= 1'b0;
      rx_endpoint_toggle_o <= 1'b0;
      mailbox_in_toggle_o <= 1'b0;
      mailbox_out_toggle_o <= 1'b0;
      tx_send_allowed_o <= 1'b0;
      wait_states_o <= 2'h0;
      usb_module_reset_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      // Read data is zero outside the cycle after a read strobe
      rdata_o <= rd_i ? rd_d : 16'h0000;
      diff_receiver_enable_o <= input_ctrl_q[`UCIR_BIT_RX_ENABLE];
      xfer_bulk_o <= input_ctrl_q[`UCIR_BIT_XFER_BULK];
      // One pulse per write of 0; the stored bit is not a held request
      remote_wake_start_o <= wr_ic && !wlo[`UCIR_BIT_WAKE_N];
      line_pullup_output_o <= pullup_q;
      string_enable_o <= string_en_q;
      max_power_o <= max_power_q;
      tx_endpoint_toggle_o <= tog_q[3];
      rx_endpoint_toggle_o <= tog_q[2];
      mailbox_in_toggle_o <= tog_q[1];
      mailbox_out_toggle_o <= tog_q[0];
      tx_send_allowed_o <= tx_fifo_has_data_i
                           && (!tx_mode_q || tx_endpoint_valid_i);
      wait_states_o <= wait_q;
      usb_module_reset_o <= wr_key;
      // Level request; software lowers it by clearing status or enables
      irq_o <= (|msk0) | (|msk1);
    end
  end
endmodule // ucir_regs

// ---- ucir_regs_assertions.sv ----
// Assertion checker for the USB config and irq register bank
`timescale 1ns/10ps
module ucir_regs_chk (
  input wire clk_i,
  input wire nrst_i,
  input wire [15:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [15:0] rdata_o,
  input wire diff_receiver_enable_o,
  input wire xfer_bulk_o,
  input wire remote_wake_start_o,
  input wire line_pullup_output_o,
  input wire [7:0] max_power_o,
  input wire [1:0] wait_states_o,
  input wire usb_module_reset_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  wire ic_wr = wr_i && addr_i == 16'h4040;
  wire key_wr = wr_i && addr_i == 16'h4052 && wdata_i[7:0] == 8'ha4;
  chk_reserved_reads_zero: assert property (
    rd_i && addr_i == 16'h4042 |=> rdata_o == 16'h0) else $error("reserved word read not zero");
  chk_key_fires_reset: assert property (
    key_wr |-> ##[1:2] usb_module_reset_o) else $error("key write gave no module reset");
  chk_reset_needs_key: assert property (
    usb_module_reset_o |-> $past(key_wr) || $past(key_wr, 2)) else $error("reset without key");
  chk_wake_on_low: assert property (
    ic_wr && !wdata_i[2] |-> ##[1:2] remote_wake_start_o) else $error("no wake pulse");
  chk_power_limit: assert property (
    max_power_o <= 8'hfa) else $error("max power above limit");
  chk_rx_enable: assert property (
    ic_wr |-> ##2 diff_receiver_enable_o == $past(wdata_i[6], 2)) else $error("rx enable wrong");
  chk_bulk_select: assert property (
    ic_wr |-> ##2 xfer_bulk_o == $past(wdata_i[3], 2)) else $error("transfer type wrong");
  chk_pullup_follows: assert property (
    wr_i && addr_i == 16'h4044 |-> ##2 line_pullup_output_o == $past(wdata_i[0], 2))
    else $error("pull-up output wrong");
  chk_wait_states: assert property (
    wr_i && addr_i == 16'h4054 |-> ##2 wait_states_o == $past(wdata_i[1:0], 2))
    else $error("wait states wrong");
  cover property (key_wr);
  cover property (ic_wr && !wdata_i[2]);
  cover property (rd_i && addr_i == 16'h4050);
endmodule // ucir_regs_chk
bind ucir_regs ucir_regs_chk ucir_regs_chk_i (.clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i,
  .rd_i, .rdata_o, .diff_receiver_enable_o, .xfer_bulk_o, .remote_wake_start_o,
  .line_pullup_output_o, .max_power_o, .wait_states_o, .usb_module_reset_o);

// ---- ucir_regs_tb.sv ----
// Self-checking bench for the USB config and irq register bank
`timescale 1ns/10ps
module ucir_regs_tb;
  logic clk_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0, valid = 0, has_data = 1;
  logic [15:0] addr_i = 0, wdata_i = 0;
  wire [15:0] rdata_o;
  wire [3:0] lv;
  wire [4:0] pv;
  wire cable, rx_en, bulk, wake, pup, str_en, t4, t3, t2, t1, send_ok, mrst, irq;
  wire [7:0] maxp;
  wire [1:0] wst;
  int fail_count = 0, cmp_count = 0, cyc = 0, wakes = 0, rsts = 0;
  ucir_host_model ucir_host_model_i (.clk_i, .lines_o(lv), .pulse_o(pv), .cable_o(cable));
  ucir_regs #(.DEBOUNCE_CYCLES(8)) ucir_regs_i (.clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i,
    .rd_i, .rdata_o, .cable_detect_input_i(cable), .host_connect_i(lv[3]),
    .host_disconnect_i(lv[2]), .dev_configured_i(lv[1]), .ep_request_i(lv[0]),
    .function_reset_event_i(pv[4]), .tx_endpoint_valid_i(valid),
    .tx_fifo_has_data_i(has_data), .tx_in_done_i(pv[3]), .rx_out_done_i(pv[2]),
    .mbox_in_done_i(pv[1]), .mbox_out_done_i(pv[0]), .diff_receiver_enable_o(rx_en),
    .xfer_bulk_o(bulk), .remote_wake_start_o(wake), .line_pullup_output_o(pup),
    .string_enable_o(str_en), .max_power_o(maxp), .tx_endpoint_toggle_o(t4),
    .rx_endpoint_toggle_o(t3), .mailbox_in_toggle_o(t2), .mailbox_out_toggle_o(t1),
    .tx_send_allowed_o(send_ok), .wait_states_o(wst), .usb_module_reset_o(mrst), .irq_o(irq));
  initial forever #2 clk_i = ~clk_i;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_i <= 1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge clk_i);
    rd_i <= 1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 0;
    #1 chk(rdata_o, e);
  endtask
  task automatic xw(input logic [15:0] i, input logic [15:0] d);
    wr(16'h4038, i);
    wr(16'h403a, d);
  endtask
  task automatic xr(input logic [15:0] i, input logic [15:0] e);
    wr(16'h4038, i);
    rd(16'h403a, e);
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (wake === 1'b1) wakes++;
    if (mrst === 1'b1) rsts++;
    if (cyc == 5000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    repeat (2) @(posedge clk_i);
    nrst_i <= 1;
    step(2);
    chk(16'({bulk, rx_en, str_en, maxp}), 16'h5fa);
    rd(16'h404a, 16'h2);
    for (int i = 8; i < 13; i++)
      xr(i[15:0], i == 8 ? 16'h1 : (i == 9 ? 16'hfa : 16'h0));
    wr(16'h4052, 16'h55);
    wr(16'h4052, 16'ha4);
    step(4);
    chk(16'(rsts), 16'h1);
    rd(16'h4052, 16'h0);
    wr(16'h4042, 16'hffff);
    rd(16'h4042, 16'h0);
    xw(16'h8, 16'h0);
    step(2);
    chk(16'(str_en), 16'h0);
    xw(16'h9, 16'hff);
    xr(16'h9, 16'hfa);
    xw(16'h9, 16'h32);
    step(2);
    chk(16'(maxp), 16'h32);
    xw(16'ha, 16'hf0);
    rd(16'h403a, 16'h0);
    step(12);
    rd(16'h403a, 16'hf0);
    chk(16'({t4, t3, t2, t1}), 16'hf);
    ucir_host_model_i.pulse(5'h09);
    step(15);
    chk(16'({t4, t3, t2, t1}), 16'h6);
    rd(16'h403a, 16'h60);
    xw(16'hc, 16'h0);
    step(4);
    chk(16'(send_ok), 16'h1);
    xw(16'hc, 16'h1);
    step(4);
    chk(16'(send_ok), 16'h0);
    @(posedge clk_i);
    valid <= 1;
    step(4);
    chk(16'(send_ok), 16'h1);
    @(posedge clk_i);
    has_data <= 0;
    step(4);
    chk(16'(send_ok), 16'h0);
    wr(16'h4040, 16'h4c);
    step(3);
    chk(16'({rx_en, bulk, 8'(wakes)}), 16'h300);
    wr(16'h4040, 16'h40);
    step(3);
    chk(16'({rx_en, bulk, 8'(wakes)}), 16'h201);
    rd(16'h4040, 16'h40);
    wr(16'h4044, 16'h1);
    step(2);
    chk(16'(pup), 16'h1);
    rd(16'h4044, 16'h3);
    ucir_host_model_i.plug(1'b0);
    rd(16'h4044, 16'h3);
    step(12);
    rd(16'h4044, 16'h1);
    wr(16'h4054, 16'h1);
    step(2);
    chk(16'(wst), 16'h1);
    wr(16'h404a, 16'hff);
    wr(16'h404c, 16'hff);
    rd(16'h404a, 16'h0);
    wr(16'h4046, 16'h42);
    wr(16'h4048, 16'h51);
    ucir_host_model_i.lines(4'hf);
    step(6);
    ucir_host_model_i.lines(4'h8);
    step(6);
    rd(16'h404a, 16'h40);
    rd(16'h404c, 16'h51);
    rd(16'h404e, 16'h40);
    rd(16'h4050, 16'h51);
    chk(16'(irq), 16'h1);
    wr(16'h4048, 16'h10);
    rd(16'h4050, 16'h10);
    wr(16'h404c, 16'h1);
    rd(16'h404c, 16'h50);
    ucir_host_model_i.lines(4'h0);
    ucir_host_model_i.pulse(5'h10);
    step(6);
    rd(16'h404a, 16'h42);
    wr(16'h404a, 16'hff);
    wr(16'h404c, 16'hff);
    step(3);
    chk(16'(irq), 16'h0);
    rd(16'h404e, 16'h0);
    summarize();
  end
endmodule // ucir_regs_tb
